// ---- src/pbcs_regs.vh ----
// Register offsets, field positions and timing constants of the PHY basic block.
`ifndef PBCS_REGS_VH
`define PBCS_REGS_VH
`define PBCS_ADDR_CONTROL 5'h00
`define PBCS_ADDR_STATUS 5'h01
`define PBCS_CTL_SPEED_LSB 13
`define PBCS_CTL_AN_ENABLE 12
`define PBCS_CTL_ISOLATE 10
`define PBCS_CTL_RESTART_AN 9
`define PBCS_CTL_DUPLEX 8
`define PBCS_CTL_COL_TEST 7
`define PBCS_CTL_SPEED_MSB 6
`define PBCS_CTL_WRITE_MASK 16'h27C0
`define PBCS_ST_AN_COMPLETE 5
`define PBCS_ST_REMOTE_FAULT 4
`define PBCS_ST_LINK 2
`define PBCS_ST_FIXED 16'h7948
`define PBCS_SPEED_10 2'h0
`define PBCS_SPEED_100 2'h1
`define PBCS_SPEED_1000 2'h2
`define PBCS_COL_ASSERT_BITS 512
`define PBCS_COL_RELEASE_BITS 4
`endif

// ---- src/pbcs_latch_bit.v ----
// One event-latched status bit that releases after a management read.
`timescale 1ns/10ps
`default_nettype none
module pbcs_latch_bit #(
  parameter IDLE_VALUE = 1'b0
)
(
  input wire ref_clk,
  input wire srst,
  input wire event_in,
  input wire release_ok,
  input wire read_done,
  output reg value
);
  // Hold the event against the idle level; a new event beats the release.
  always @(posedge ref_clk)
  begin
    // Both latches power up showing no event and no link, so reset is low.
    if (srst)
      value <= 1'b0;
    else if (event_in)
      value <= ~IDLE_VALUE;
    else if (read_done && release_ok)
      value <= IDLE_VALUE;
  end
endmodule
`default_nettype wire

// ---- src/pbcs_basic_regs.v ----
// Basic mode control and status registers of an Ethernet PHY.
`timescale 1ns/10ps
`default_nettype none
`include "pbcs_regs.vh"
module pbcs_basic_regs #(
  parameter CLK_PERIOD_NS = 50,
  parameter BIT_TIME_NS = 100
)
(
  input wire ref_clk,
  input wire srst,
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  input wire strap_an_enable,
  input wire strap_full_duplex,
  input wire an_started,
  input wire an_complete,
  input wire far_end_fault,
  input wire partner_remote_fault,
  input wire link_good,
  input wire tx_en,
  output wire an_restart,
  output wire an_enable,
  output wire mii_isolate,
  output wire forced_full_duplex,
  output wire [1:0] forced_speed,
  output reg col
);
  // Bit-time budgets turned into clock counts; both round down,
  // and never below one cycle.
  localparam ASSERT_NS = `PBCS_COL_ASSERT_BITS * BIT_TIME_NS;
  localparam RELEASE_NS = `PBCS_COL_RELEASE_BITS * BIT_TIME_NS;
  localparam ASSERT_CYC_RAW = ASSERT_NS / CLK_PERIOD_NS;
  localparam RELEASE_CYC_RAW = RELEASE_NS / CLK_PERIOD_NS;
  localparam ASSERT_CYC = (ASSERT_CYC_RAW < 1) ? 1 : ASSERT_CYC_RAW;
  localparam RELEASE_CYC = (RELEASE_CYC_RAW < 1) ? 1 : RELEASE_CYC_RAW;
  localparam S_IDLE = 3'b001;
  localparam S_RESTART = 3'b010;
  localparam S_RUN = 3'b100;

  ////////////////////////////////////////////////////////////////////////
  reg [15:0] ctl;
  reg [2:0] an_state;
  reg [2:0] next_an_state;
  reg strap_seen;
  wire wr_ctl;
  wire rd_status;
  wire remote_fault;
  wire link_status;

  assign wr_ctl = reg_wr && (reg_addr == `PBCS_ADDR_CONTROL);
  assign rd_status = reg_rd && (reg_addr == `PBCS_ADDR_STATUS);

  // Straps are caught by a clocked process in the first cycle after reset.
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctl <= 16'h0040;
      strap_seen <= 1'b0;
    end
    else
    begin
      if (!strap_seen)
      begin
        strap_seen <= 1'b1;
        ctl[`PBCS_CTL_AN_ENABLE] <= strap_an_enable;
        ctl[`PBCS_CTL_DUPLEX] <= strap_full_duplex;
      end
      else if (wr_ctl)
      begin
        ctl[`PBCS_CTL_SPEED_LSB] <= reg_wdata[`PBCS_CTL_SPEED_LSB];
        ctl[`PBCS_CTL_AN_ENABLE] <= reg_wdata[`PBCS_CTL_AN_ENABLE];
        ctl[`PBCS_CTL_ISOLATE] <= reg_wdata[`PBCS_CTL_ISOLATE];
        ctl[`PBCS_CTL_DUPLEX] <= reg_wdata[`PBCS_CTL_DUPLEX];
        ctl[`PBCS_CTL_COL_TEST] <= reg_wdata[`PBCS_CTL_COL_TEST];
        ctl[`PBCS_CTL_SPEED_MSB] <= reg_wdata[`PBCS_CTL_SPEED_MSB];
      end
      // Restart bit: set only while negotiation is enabled, cleared by
      // hardware at start or by software without stopping the process.
      if (wr_ctl && reg_wdata[`PBCS_CTL_RESTART_AN]
          && reg_wdata[`PBCS_CTL_AN_ENABLE] && strap_seen)
        ctl[`PBCS_CTL_RESTART_AN] <= 1'b1;
      else if (an_state == S_RUN && an_started)
        ctl[`PBCS_CTL_RESTART_AN] <= 1'b0;
      else if (wr_ctl && strap_seen)
        ctl[`PBCS_CTL_RESTART_AN] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // The restart request is pulsed once through S_RESTART and kept
  // pending in S_RUN until the engine confirms start, so a software clear
  // of the visible bit cannot cancel it.
  always @*
  begin
    next_an_state = an_state;
    case (an_state)
      S_IDLE:
        if (wr_ctl && strap_seen && reg_wdata[`PBCS_CTL_RESTART_AN]
            && reg_wdata[`PBCS_CTL_AN_ENABLE])
          next_an_state = S_RESTART;
      S_RESTART:
        next_an_state = S_RUN;
      S_RUN:
        if (an_started)
          next_an_state = S_IDLE;
      default:
        next_an_state = S_IDLE;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (srst)
      an_state <= S_IDLE;
    else
      an_state <= next_an_state;
  end

  assign an_restart = (an_state == S_RESTART);
  assign an_enable = ctl[`PBCS_CTL_AN_ENABLE];
  assign mii_isolate = ctl[`PBCS_CTL_ISOLATE];
  // Forced duplex and the speed LSB are held at zero when negotiation owns
  // the link; the speed MSB still passes through from the control register.
  assign forced_full_duplex = an_enable ? 1'b0
                            : ctl[`PBCS_CTL_DUPLEX];
  assign forced_speed = {ctl[`PBCS_CTL_SPEED_MSB],
                         an_enable ? 1'b0
                         : ctl[`PBCS_CTL_SPEED_LSB]};

  ////////////////////////////////////////////////////////////////////////
  // Collision test: col follows tx_en after delays equal to the two budgets,
  // 512 bit times to assert and 4 to release. Isolation also silences it since the port is detached.
  reg [15:0] col_cnt;
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      col <= 1'b0;
      col_cnt <= 16'h0000;
    end
    else if (!ctl[`PBCS_CTL_COL_TEST] || mii_isolate)
    begin
      col <= 1'b0;
      col_cnt <= 16'h0000;
    end
    else if (tx_en != col)
    begin
      if (tx_en && col_cnt >= ASSERT_CYC[15:0] - 16'h0001)
      begin
        col <= 1'b1;
        col_cnt <= 16'h0000;
      end
      else if (!tx_en && col_cnt >= RELEASE_CYC[15:0] - 16'h0001)
      begin
        col <= 1'b0;
        col_cnt <= 16'h0000;
      end
      else
        col_cnt <= col_cnt + 16'h0001;
    end
    else
      col_cnt <= 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  pbcs_latch_bit #(
    .IDLE_VALUE(1'b0)
  )
  u_remote_fault
  (
    .ref_clk(ref_clk),
    .srst(srst),
    .event_in(far_end_fault || partner_remote_fault),
    .release_ok(1'b1),
    .read_done(rd_status),
    .value(remote_fault)
  );

  // Link latch resets low and may rise only through a read with good link.
  pbcs_latch_bit #(
    .IDLE_VALUE(1'b1)
  )
  u_link
  (
    .ref_clk(ref_clk),
    .srst(srst),
    .event_in(~link_good),
    .release_ok(link_good),
    .read_done(rd_status),
    .value(link_status)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read data are registered; the latches are sampled in the same cycle
  // they release, so the returned value is the one held before the read.
  always @(posedge ref_clk)
  begin
    if (srst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      if (reg_addr == `PBCS_ADDR_CONTROL)
        reg_rdata <= ctl & `PBCS_CTL_WRITE_MASK
                     | (ctl & 16'h1000);
      else if (reg_addr == `PBCS_ADDR_STATUS)
      begin
        reg_rdata <= `PBCS_ST_FIXED;
        reg_rdata[`PBCS_ST_AN_COMPLETE] <= an_complete;
        reg_rdata[`PBCS_ST_REMOTE_FAULT] <= remote_fault;
        reg_rdata[`PBCS_ST_LINK] <= link_status;
      end
      else
        reg_rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ---- test/pbcs_an_engine.sv ----
// Negotiation engine stand-in that answers restart requests late.
`timescale 1ns/10ps
`default_nettype none
module pbcs_an_engine #(
  parameter int DELAY = 20
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic an_restart,
  output var logic an_started,
  output var int starts
);
  int cnt;
  // The answer comes late so a read can still see the request bit set.
  always @(posedge ref_clk)
  begin
    an_started <= !srst && cnt == 1;
    if (srst)
      cnt <= 0;
    else if (an_restart)
      cnt <= DELAY;
    else if (cnt > 0)
      cnt <= cnt - 1;
    if (srst)
      starts <= 0;
    else if (cnt == 1)
      starts <= starts + 1;
  end
endmodule
`default_nettype wire

// ---- test/pbcs_basic_regs_checker.sv ----
// Port-level assertions for the PHY basic register block.
`timescale 1ns/10ps
`default_nettype none
module pbcs_basic_regs_checker (
  input wire ref_clk,
  input wire srst,
  input wire [4:0] reg_addr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire tx_en,
  input wire an_restart,
  input wire an_enable,
  input wire mii_isolate,
  input wire forced_full_duplex,
  input wire [1:0] forced_speed,
  input wire col
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  sequence s_tx_idle;
    !tx_en [*8];
  endsequence
  property p_st_fixed;
    reg_rd && reg_addr == 5'h01 |=> (reg_rdata & 16'hFFC8) == 16'h7948;
  endproperty
  property p_ctl_rsvd;
    reg_rd && reg_addr == 5'h00 |=> reg_rdata[5:0] == 6'h00;
  endproperty
  property p_rd_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  property p_restart_gate;
    an_restart |-> an_enable;
  endproperty
  property p_restart_once;
    an_restart |=> !an_restart;
  endproperty
  property p_an_masks;
    an_enable |-> !forced_speed[0] && !forced_full_duplex;
  endproperty
  property p_col_drop;
    s_tx_idle |=> !col;
  endproperty
  property p_col_rise;
    $rose(col) |-> $past(tx_en) && $past(tx_en, 2);
  endproperty
  property p_iso_col;
    mii_isolate [*2] |-> !col;
  endproperty
  a_st_fixed: assert property (p_st_fixed)
    else $error("fixed status bits wrong");
  a_ctl_rsvd: assert property (p_ctl_rsvd)
    else $error("reserved control bits not zero");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
  a_restart_gate: assert property (p_restart_gate)
    else $error("restart while negotiation disabled");
  a_restart_once: assert property (p_restart_once)
    else $error("restart request longer than one cycle");
  a_an_masks: assert property (p_an_masks)
    else $error("forced settings leak with negotiation on");
  a_col_drop: assert property (p_col_drop)
    else $error("collision held after transmit ended");
  a_col_rise: assert property (p_col_rise)
    else $error("collision without transmit");
  a_iso_col: assert property (p_iso_col)
    else $error("collision shown while isolated");
endmodule
bind pbcs_basic_regs pbcs_basic_regs_checker u_chk (.*);
`default_nettype wire

// ---- test/test_pbcs_basic_regs.sv ----
// Directed bench for the PHY basic control and status registers.
`timescale 1ns/10ps
`default_nettype none
module test_pbcs_basic_regs;
  logic ref_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, tx_en = 0;
  logic an_complete = 0, far_end_fault = 0, partner_remote_fault = 0;
  logic link_good = 1, an_started, col, an_restart, an_enable;
  logic mii_isolate, forced_full_duplex;
  logic [4:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, d;
  logic [1:0] forced_speed, s;
  int errors = 0, samples_checked = 0, starts;
  pbcs_basic_regs u_pbcs_basic_regs (.strap_an_enable(1'b0),
    .strap_full_duplex(1'b1), .*);
  pbcs_an_engine u_pbcs_an_engine (.*);
  initial forever #25 ref_clk = ~ref_clk;
  initial
  begin
    #300000;
    errors++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic summarize();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(5'h00, 16'h0140);
    rd(5'h01, 16'h7948);
    rd(5'h01, 16'h794C);
    rd(5'h05, 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      s = i[1:0];
      d = 16'h03BF | (s[1] ? 16'h0040 : 16'h0) | (s[0] ? 16'h2000 : 16'h0);
      wr(5'h00, d);
      chk({14'h0, forced_speed}, {14'h0, s});
      chk({15'h0, forced_full_duplex}, 16'h0001);
      rd(5'h00, d & 16'h21C0);
    end
    wr(5'h00, 16'h0080);
    @(posedge ref_clk);
    tx_en <= 1'b1;
    repeat (1030) @(posedge ref_clk);
    chk({15'h0, col}, 16'h0001);
    tx_en <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk({15'h0, col}, 16'h0000);
    wr(5'h00, 16'h0400);
    chk({15'h0, mii_isolate}, 16'h0001);
    wr(5'h00, 16'h3140);
    chk({14'h0, forced_speed}, 16'h0002);
    chk({15'h0, forced_full_duplex}, 16'h0000);
    wr(5'h00, 16'h1240);
    rd(5'h00, 16'h1240);
    wr(5'h00, 16'h1040);
    repeat (25) @(posedge ref_clk);
    chk(starts[15:0], 16'h0001);
    rd(5'h00, 16'h1040);
    wr(5'h00, 16'h1240);
    repeat (25) @(posedge ref_clk);
    rd(5'h00, 16'h1040);
    chk(starts[15:0], 16'h0002);
    @(posedge ref_clk);
    an_complete <= 1'b1;
    far_end_fault <= 1'b1;
    link_good <= 1'b0;
    @(posedge ref_clk);
    far_end_fault <= 1'b0;
    link_good <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(5'h01, 16'h7978);
    rd(5'h01, 16'h796C);
    @(posedge ref_clk);
    partner_remote_fault <= 1'b1;
    @(posedge ref_clk);
    partner_remote_fault <= 1'b0;
    rd(5'h01, 16'h797C);
    // A mid-run reset must drop a pending remote fault and the link latch.
    @(posedge ref_clk);
    partner_remote_fault <= 1'b1;
    @(posedge ref_clk);
    partner_remote_fault <= 1'b0;
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(5'h01, 16'h7968);
    rd(5'h00, 16'h0140);
    summarize();
  end
endmodule
`default_nettype wire
